// ---- hdl/ufc_pkg.sv ----
// Purpose: constants and carriers for the UART FIFO and line format control
// Assumes: 8-bit parallel host bus, 16x baud tick from an external generator
// Notes: register offsets are the 3-bit host address
//
// Summary of operation
// R1: FIFO configuration register is write only; reads return nothing from it.
// R2: RX threshold code 00/01/10/11 gives 8/16/56/60 characters.
// R3: TX threshold code 00/01/10/11 gives 8/16/32/56 free spaces.
// R4: TX threshold field changes only while enhanced functions enable is set.
// R5: FIFO configuration bit 3 selects DMA signalling mode 0 or 1.
// R6: Writing bit 2 empties TX FIFO, keeps shift register; bit self-clears.
// R7: Writing bit 1 empties RX FIFO, keeps shift register; bit self-clears.
// R8: Bit 0 enables both FIFOs; reset value 0 leaves them disabled.
// R9: Character format bit 7 enables divisor latch access; resets to 0.
// R10: Character format bit 6 holds serial output low until written back to 0.
// R11: Forced parity: bit 4 at 0 sends/expects 1, at 1 sends/expects 0.
// R12: Unforced parity: bit 4 at 0 odd, at 1 even.
// R13: Bit 3 adds a parity bit on transmit and checks it on receive.
// R14: Bit 2 at 0 gives 1 stop bit, else 1.5 for 5-bit or 2 otherwise.
// R15: Bits 1-0 give 5, 6, 7 or 8 data bits.
// R16: Divisor latch pair is reachable only while divisor latch enable is 1.
// R17: Enhanced and flow character registers reachable only when format is 0xbf.
// R18: Requests raise when RX fill or TX free space reaches its threshold.
package ufc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [2:0] UFC_ADDR_DATA = 3'h0;
  localparam logic [2:0] UFC_ADDR_DIVH = 3'h1;
  localparam logic [2:0] UFC_ADDR_FIFO = 3'h2;
  localparam logic [2:0] UFC_ADDR_FMT = 3'h3;
  localparam logic [7:0] UFC_ENH_KEY = 8'hbf;
  localparam logic [7:0] UFC_FMT_RST = 8'h00;
  localparam logic [7:0] UFC_FIFO_RST = 8'h00;
  localparam logic [7:0] UFC_ENH_RST = 8'h00;
  localparam int UFC_ENH_EN_BIT = 4;

  // ----------------------------------------------------------------------
  // Thresholds and bit timing
  // ----------------------------------------------------------------------
  localparam int UFC_DEPTH = 64;
  localparam logic [6:0] UFC_RX_LVL0 = 7'h08;
  localparam logic [6:0] UFC_RX_LVL1 = 7'h10;
  localparam logic [6:0] UFC_RX_LVL2 = 7'h38;
  localparam logic [6:0] UFC_RX_LVL3 = 7'h3c;
  localparam logic [6:0] UFC_TX_LVL0 = 7'h08;
  localparam logic [6:0] UFC_TX_LVL1 = 7'h10;
  localparam logic [6:0] UFC_TX_LVL2 = 7'h20;
  localparam logic [6:0] UFC_TX_LVL3 = 7'h38;
  localparam logic [5:0] UFC_BIT_TICKS = 6'h10;
  localparam logic [5:0] UFC_HALF_TICKS = 6'h08;
  localparam logic [5:0] UFC_STOP15_TICKS = 6'h18;
  localparam logic [5:0] UFC_STOP2_TICKS = 6'h20;
  localparam logic [2:0] UFC_LAST_BIT5 = 3'h4;

  typedef struct packed {
    logic dlab;
    logic brk;
    logic force_par;
    logic even_sel;
    logic par_en;
    logic stop_long;
    logic [1:0] wlen;
  } ufc_fmt_s;

  typedef struct packed {
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic dma;
    logic tx_clr;
    logic rx_clr;
    logic fen;
  } ufc_fifo_cfg_s;

  typedef enum {UFC_SER_IDLE, UFC_SER_START, UFC_SER_DATA, UFC_SER_PAR, UFC_SER_STOP} ufc_ser_e;

endpackage : ufc_pkg

// ---- hdl/ufc_fifo.sv ----
// Purpose: synchronous FIFO with valid/ready on both sides and a flush
// Assumes: single clock, synchronous active-high reset
// Notes: flush empties pointers only; stored words are left stale
`timescale 1ns/1ps
module ufc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[flush ? '0 : wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || flush)
    begin
      // A word pushed in the flush cycle survives as the only entry
      wr_ptr <= (push && !rst) ? AW'(1) : '0;
      rd_ptr <= '0;
      count <= (push && !rst) ? CW'(1) : '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      if (push && !pop)
      begin
        count <= CW'(count + 1'b1);
      end
      else if (pop && !push)
      begin
        count <= CW'(count - 1'b1);
      end
    end
  end

endmodule : ufc_fifo

// ---- hdl/ufc_line_ctrl.sv ----
// Purpose: FIFO control and character format of one UART channel
// Assumes: bus strobes are one-cycle pulses synchronous to core_clk
// Notes: baud_tick16 pulses sixteen times per bit period
`timescale 1ns/1ps
module ufc_line_ctrl #(
  parameter int DEPTH = ufc_pkg::UFC_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_cs,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic baud_tick16,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic rx_request,
  output logic tx_request,
  output logic dma_mode,
  output logic [15:0] divisor,
  output logic enhanced_functions_enable
);
  import ufc_pkg::*;
  localparam int CW = $clog2(DEPTH+1);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  ufc_fmt_s fmt;
  ufc_fifo_cfg_s fcfg;
  logic [7:0] enh_reg;
  logic [7:0] xchr [4];
  logic wr_en;
  logic rd_en;
  logic enh_sel;

  assign wr_en = bus_cs && bus_wr;
  assign rd_en = bus_cs && bus_rd;
  assign enh_sel = (fmt == ufc_fmt_s'(UFC_ENH_KEY));

  // FIFO signals
  logic txf_in_valid;
  logic txf_in_ready;
  logic txf_out_valid;
  logic txf_out_ready;
  logic [7:0] txf_out_data;
  logic [CW-1:0] txf_count;
  logic rxf_in_valid;
  logic rxf_in_ready;
  logic rxf_out_valid;
  logic rxf_out_ready;
  logic [9:0] rxf_in_data;
  logic [9:0] rxf_out_data;
  logic [CW-1:0] rxf_count;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fmt <= ufc_fmt_s'(UFC_FMT_RST); // R9
    end
    else if (wr_en && bus_addr == UFC_ADDR_FMT)
    begin
      fmt <= ufc_fmt_s'(bus_wdata);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fcfg <= ufc_fifo_cfg_s'(UFC_FIFO_RST); // R8
      dma_mode <= 1'b0;
    end
    else
    begin
      fcfg.tx_clr <= 1'b0; // R6
      fcfg.rx_clr <= 1'b0; // R7
      if (wr_en && bus_addr == UFC_ADDR_FIFO && !fmt.dlab)
      begin
        fcfg.rx_trig <= bus_wdata[7:6]; // R2
        if (enhanced_functions_enable)
        begin
          fcfg.tx_trig <= bus_wdata[5:4]; // R4
        end
        fcfg.dma <= bus_wdata[3];
        dma_mode <= bus_wdata[3]; // R5
        fcfg.tx_clr <= bus_wdata[2]; // R6
        fcfg.rx_clr <= bus_wdata[1]; // R7
        fcfg.fen <= bus_wdata[0]; // R8
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      divisor <= '0;
    end
    else if (wr_en && fmt.dlab && bus_addr == UFC_ADDR_DATA)
    begin
      divisor[7:0] <= bus_wdata; // R16
    end
    else if (wr_en && fmt.dlab && bus_addr == UFC_ADDR_DIVH)
    begin
      divisor[15:8] <= bus_wdata; // R16
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      enh_reg <= UFC_ENH_RST;
      enhanced_functions_enable <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        xchr[i] <= '0;
      end
    end
    else if (wr_en && enh_sel)
    begin
      if (bus_addr == UFC_ADDR_FIFO)
      begin
        enh_reg <= bus_wdata; // R17
        enhanced_functions_enable <= bus_wdata[UFC_ENH_EN_BIT];
      end
      if (bus_addr[2])
      begin
        xchr[bus_addr[1:0]] <= bus_wdata; // R17
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Receive data pops only outside divisor access
  assign rxf_out_ready = rd_en && bus_addr == UFC_ADDR_DATA && !fmt.dlab;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bus_rdata <= '0;
    end
    else if (rd_en)
    begin
      bus_rdata <= '0;
      if (bus_addr == UFC_ADDR_DATA)
      begin
        if (fmt.dlab)
        begin
          bus_rdata <= divisor[7:0]; // R16
        end
        else if (rxf_out_valid)
        begin
          bus_rdata <= rxf_out_data[7:0];
        end
      end
      else if (bus_addr == UFC_ADDR_DIVH && fmt.dlab)
      begin
        bus_rdata <= divisor[15:8]; // R16
      end
      else if (bus_addr == UFC_ADDR_FIFO && enh_sel)
      begin
        bus_rdata <= enh_reg; // R1 R17
      end
      else if (bus_addr == UFC_ADDR_FMT)
      begin
        bus_rdata <= fmt;
      end
      else if (bus_addr[2] && enh_sel)
      begin
        bus_rdata <= xchr[bus_addr[1:0]]; // R17
      end
    end
  end

  // ----------------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------------
  // With FIFOs disabled only one character is held; extra ones are lost
  assign txf_in_valid = wr_en && bus_addr == UFC_ADDR_DATA && !fmt.dlab
                        && (fcfg.fen || txf_count == '0); // R8

  ufc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txf (
    .core_clk(core_clk),
    .rst(rst),
    .flush(fcfg.tx_clr),
    .in_valid(txf_in_valid),
    .in_ready(txf_in_ready),
    .in_data(bus_wdata),
    .out_valid(txf_out_valid),
    .out_ready(txf_out_ready),
    .out_data(txf_out_data),
    .count(txf_count)
  );

  ufc_fifo #(.WIDTH(10), .DEPTH(DEPTH)) u_rxf (
    .core_clk(core_clk),
    .rst(rst),
    .flush(fcfg.rx_clr),
    .in_valid(rxf_in_valid),
    .in_ready(rxf_in_ready),
    .in_data(rxf_in_data),
    .out_valid(rxf_out_valid),
    .out_ready(rxf_out_ready),
    .out_data(rxf_out_data),
    .count(rxf_count)
  );

  // ----------------------------------------------------------------------
  // Threshold requests
  // ----------------------------------------------------------------------
  logic [6:0] rx_lvl;
  logic [6:0] tx_lvl;
  always_comb
  begin
    case (fcfg.rx_trig) // R2
      2'h0: rx_lvl = UFC_RX_LVL0;
      2'h1: rx_lvl = UFC_RX_LVL1;
      2'h2: rx_lvl = UFC_RX_LVL2;
      default: rx_lvl = UFC_RX_LVL3;
    endcase
    case (fcfg.tx_trig) // R3
      2'h0: tx_lvl = UFC_TX_LVL0;
      2'h1: tx_lvl = UFC_TX_LVL1;
      2'h2: tx_lvl = UFC_TX_LVL2;
      default: tx_lvl = UFC_TX_LVL3;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rx_request <= 1'b0;
      tx_request <= 1'b0;
    end
    else
    begin
      rx_request <= 32'(rxf_count) >= 32'(rx_lvl); // R18
      tx_request <= (DEPTH - 32'(txf_count)) >= 32'(tx_lvl); // R18
    end
  end

  // ----------------------------------------------------------------------
  // Character format helpers
  // ----------------------------------------------------------------------
  function automatic logic ufc_parity(input logic [7:0] d, input ufc_fmt_s f);
    logic [7:0] m;
    m = d & (8'hff >> (2'h3 - f.wlen)); // R15
    if (f.force_par)
    begin
      return !f.even_sel; // R11
    end
    return f.even_sel ? ^m : ~^m; // R12
  endfunction : ufc_parity

  logic [2:0] last_bit;
  logic [5:0] stop_ticks;
  assign last_bit = UFC_LAST_BIT5 + {1'b0, fmt.wlen}; // R15
  assign stop_ticks = !fmt.stop_long ? UFC_BIT_TICKS :
                      (fmt.wlen == 2'h0) ? UFC_STOP15_TICKS : UFC_STOP2_TICKS; // R14

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  ufc_ser_e tx_st;
  logic [5:0] tx_tcnt;
  logic [2:0] tx_bits;
  logic [7:0] tx_hold;
  logic tx_bit;
  logic tx_end;

  assign txf_out_ready = (tx_st == UFC_SER_IDLE);
  assign tx_end = baud_tick16 &&
                  (tx_tcnt == ((tx_st == UFC_SER_STOP) ? stop_ticks : UFC_BIT_TICKS) - 6'h1);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_st <= UFC_SER_IDLE;
      tx_tcnt <= '0;
      tx_bits <= '0;
      tx_hold <= '0;
      tx_bit <= 1'b1;
    end
    else if (tx_st == UFC_SER_IDLE)
    begin
      tx_tcnt <= '0;
      if (txf_out_valid)
      begin
        tx_hold <= txf_out_data;
        tx_st <= UFC_SER_START;
        tx_bit <= 1'b0;
      end
    end
    else if (baud_tick16)
    begin
      tx_tcnt <= tx_end ? '0 : 6'(tx_tcnt + 6'h1);
      if (tx_end)
      begin
        case (tx_st)
          UFC_SER_START:
          begin
            tx_st <= UFC_SER_DATA;
            tx_bits <= '0;
            tx_bit <= tx_hold[0];
          end
          UFC_SER_DATA:
          begin
            if (tx_bits == last_bit)
            begin
              tx_st <= fmt.par_en ? UFC_SER_PAR : UFC_SER_STOP; // R13
              tx_bit <= fmt.par_en ? ufc_parity(tx_hold, fmt) : 1'b1; // R13
            end
            else
            begin
              tx_bits <= 3'(tx_bits + 3'h1);
              tx_bit <= tx_hold[3'(tx_bits + 3'h1)];
            end
          end
          UFC_SER_PAR:
          begin
            tx_st <= UFC_SER_STOP;
            tx_bit <= 1'b1;
          end
          default:
          begin
            tx_st <= UFC_SER_IDLE;
            tx_bit <= 1'b1;
          end
        endcase
      end
    end
  end

  // Break overrides the shifter but lets it run on
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_pin <= 1'b1;
    end
    else
    begin
      tx_pin <= fmt.brk ? 1'b0 : tx_bit; // R10
    end
  end

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------
  ufc_ser_e rx_st;
  logic [5:0] rx_tcnt;
  logic [2:0] rx_bits;
  logic [7:0] rx_sh;
  logic rx_perr;
  logic rx_push;
  logic rx_mid;

  // Sampling re-bases on mid start bit, so later samples land mid bit
  assign rx_mid = baud_tick16 && (rx_tcnt == ((rx_st == UFC_SER_START) ?
                  UFC_HALF_TICKS : UFC_BIT_TICKS) - 6'h1);
  assign rxf_in_valid = rx_push && (fcfg.fen || rxf_count == '0); // R8

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rx_st <= UFC_SER_IDLE;
      rx_tcnt <= '0;
      rx_bits <= '0;
      rx_sh <= '0;
      rx_perr <= 1'b0;
      rx_push <= 1'b0;
      rxf_in_data <= '0;
    end
    else
    begin
      rx_push <= 1'b0;
      if (rx_st == UFC_SER_IDLE)
      begin
        rx_tcnt <= '0;
        if (baud_tick16 && !rx_pin)
        begin
          rx_st <= UFC_SER_START;
          rx_sh <= '0;
          rx_perr <= 1'b0;
        end
      end
      else if (baud_tick16)
      begin
        rx_tcnt <= rx_mid ? '0 : 6'(rx_tcnt + 6'h1);
        if (rx_mid)
        begin
          case (rx_st)
            UFC_SER_START:
            begin
              rx_st <= rx_pin ? UFC_SER_IDLE : UFC_SER_DATA;
              rx_bits <= '0;
            end
            UFC_SER_DATA:
            begin
              rx_sh[rx_bits] <= rx_pin;
              rx_bits <= 3'(rx_bits + 3'h1);
              if (rx_bits == last_bit) // R15
              begin
                rx_st <= fmt.par_en ? UFC_SER_PAR : UFC_SER_STOP; // R13
              end
            end
            UFC_SER_PAR:
            begin
              rx_perr <= rx_pin != ufc_parity(rx_sh, fmt); // R11 R12 R13
              rx_st <= UFC_SER_STOP;
            end
            default:
            begin
              rxf_in_data <= {!rx_pin, rx_perr, rx_sh};
              rx_push <= 1'b1;
              rx_st <= UFC_SER_IDLE;
            end
          endcase
        end
      end
    end
  end

endmodule : ufc_line_ctrl

// ---- verification/ufc_line_ctrl_assertions.sv ----
// Purpose: concurrent checks on the line control ports
// Assumes: sees only the ports of ufc_line_ctrl
// Notes: shadows the format register to know which bank is open
`timescale 1ns/1ps
module ufc_line_ctrl_assertions
  import ufc_pkg::*;
#(
  parameter int DEPTH = 64
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_cs,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic baud_tick16,
  input wire logic rx_pin,
  input wire logic tx_pin,
  input wire logic rx_request,
  input wire logic tx_request,
  input wire logic dma_mode,
  input wire logic [15:0] divisor,
  input wire logic enhanced_functions_enable
);
  logic [7:0] fmt;
  logic wf;
  logic wd;
  assign wf = bus_cs && bus_wr && bus_addr == UFC_ADDR_FIFO;
  assign wd = bus_cs && bus_wr && bus_addr == UFC_ADDR_DIVH;
  always_ff @(posedge core_clk)
  begin
    if (rst)
      fmt <= 8'h00;
    else if (bus_cs && bus_wr && bus_addr == UFC_ADDR_FMT)
      fmt <= bus_wdata;
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Reset itself is the cause here, so it must not disable the check
  property p_reset;
    disable iff (1'b0) rst |=> tx_pin && !rx_request && !dma_mode && divisor == 16'h0000
      && !enhanced_functions_enable;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  property p_fifo_wo;
    bus_cs && bus_rd && bus_addr == UFC_ADDR_FIFO && fmt != UFC_ENH_KEY |=> bus_rdata == 8'h00;
  endproperty
  a_fifo_wo: assert property (p_fifo_wo) else $error("fifo config readable");
  property p_dma;
    wf && !fmt[7] |=> dma_mode == $past(bus_wdata[3]);
  endproperty
  a_dma: assert property (p_dma) else $error("dma mode not taken");
  property p_brk;
    fmt[6] |=> !tx_pin;
  endproperty
  a_brk: assert property (p_brk) else $error("break not driven");
  property p_div_lock;
    wd && !fmt[7] |=> $stable(divisor);
  endproperty
  a_div_lock: assert property (p_div_lock) else $error("divisor written while locked");
  property p_div_hi;
    wd && fmt[7] && fmt != UFC_ENH_KEY |=> divisor[15:8] == $past(bus_wdata);
  endproperty
  a_div_hi: assert property (p_div_hi) else $error("divisor high not written");
  property p_enh;
    wf && fmt == UFC_ENH_KEY |=> enhanced_functions_enable == $past(bus_wdata[4]);
  endproperty
  a_enh: assert property (p_enh) else $error("enhanced enable not written");
  property p_enh_lock;
    wf && fmt != UFC_ENH_KEY |=> $stable(enhanced_functions_enable);
  endproperty
  a_enh_lock: assert property (p_enh_lock) else $error("enhanced enable leaked");
  property p_tx_clr;
    wf && !fmt[7] && bus_wdata[2] |=> ##[1:3] tx_request;
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx clear left data");
  property p_rx_clr;
    wf && !fmt[7] && bus_wdata[1] |=> ##[1:3] !rx_request;
  endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("rx clear left data");
  c_brk: cover property (fmt[6] ##1 !tx_pin);
  c_enh: cover property (wf && fmt == UFC_ENH_KEY);
  c_rxreq: cover property (!rx_request ##1 rx_request);
endmodule : ufc_line_ctrl_assertions

// ---- verification/ufc_serial_peer.sv ----
// Purpose: far-end serial device for the line control bench
// Assumes: fixed bit time of BITC core clocks
// Notes: line idles high between frames, as a pulled-up line would
`timescale 1ns/1ps
module ufc_serial_peer #(
  parameter int BITC = 32
) (
  input wire logic core_clk,
  input wire logic tx_pin,
  output logic rx_pin
);
  initial rx_pin = 1'b1;
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      rx_pin <= f[i];
      repeat (BITC - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    rx_pin <= 1'b1;
  endtask : send
  // Entered at the start edge; returns at the centre of the last bit
  task automatic recv(input int n, output logic [11:0] f);
    f = 12'hfff;
    repeat (BITC / 2) @(posedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      if (i > 0) repeat (BITC) @(posedge core_clk);
      f[i] = tx_pin;
    end
  endtask : recv
endmodule : ufc_serial_peer

// ---- verification/ufc_line_ctrl_tb.sv ----
// Purpose: self-checking bench for ufc_line_ctrl
// Assumes: baud tick every second clock, so one bit is 32 clocks
// Notes: stop length is timed between two back-to-back characters
`timescale 1ns/1ps
module ufc_line_ctrl_tb;
  import ufc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] bus_addr = 3'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_cs = 1'b0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic baud_tick16 = 1'b0;
  logic [7:0] bus_rdata;
  logic rx_pin, tx_pin, rx_request, tx_request, dma_mode, enhanced_functions_enable;
  logic [15:0] divisor;
  int seed = 32'h44243206;
  int miscompares = 0;
  int checked = 0;
  int n;
  int sl;
  time t0;
  logic [7:0] d, r, fm, hi, lo;
  logic [11:0] f, g;
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) baud_tick16 <= ~baud_tick16;
  ufc_line_ctrl #(.DEPTH(64)) ufc_line_ctrl_i (.core_clk(core_clk), .rst(rst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_cs(bus_cs), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .baud_tick16(baud_tick16), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .rx_request(rx_request), .tx_request(tx_request), .dma_mode(dma_mode),
    .divisor(divisor), .enhanced_functions_enable(enhanced_functions_enable));
  ufc_serial_peer #(.BITC(32)) ufc_serial_peer_i (.core_clk(core_clk), .tx_pin(tx_pin),
    .rx_pin(rx_pin));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk);
    bus_cs <= 1'b1;
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge core_clk);
    bus_cs <= 1'b0;
    bus_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge core_clk);
    bus_cs <= 1'b1;
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_cs <= 1'b0;
    bus_rd <= 1'b0;
    @(posedge core_clk);
    v = bus_rdata;
  endtask : rd
  // Idle length must beat two stop bits, else a gap in a burst passes
  task automatic wait_tx(input logic lvl, input int len);
    int k;
    int h;
    h = 0;
    for (k = 0; k < 4000 && h < len; k++)
    begin
      @(posedge core_clk);
      h = (tx_pin === lvl) ? h + 1 : 0;
    end
    if (h < len)
    begin
      miscompares++;
      summarize();
    end
  endtask : wait_tx
  function automatic int frame(input logic [7:0] fmt, input logic [7:0] v,
    output logic [11:0] fr);
    int nb;
    logic [7:0] m;
    logic p;
    nb = 5 + int'(fmt[1:0]);
    m = 8'hff >> (3 - fmt[1:0]);
    p = fmt[5] ? ~fmt[4] : (fmt[4] ? ^(v & m) : ~^(v & m));
    fr = 12'hfff;
    fr[0] = 1'b0;
    for (int i = 0; i < nb; i++) fr[1 + i] = v[i];
    if (fmt[3]) fr[1 + nb] = p;
    return 2 + nb + int'(fmt[3]);
  endfunction : frame
  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    cmp_val(16'({tx_pin, rx_request, tx_request, dma_mode, enhanced_functions_enable}), 16'h14);
    cmp_val(divisor, 16'h0000);
    rd(UFC_ADDR_FIFO, r);
    cmp_val(16'(r), 16'h0000);
    rd(UFC_ADDR_FMT, r);
    cmp_val(16'(r), 16'h0000);
    wr(UFC_ADDR_DIVH, 8'h5a);
    @(posedge core_clk);
    cmp_val(divisor, 16'h0000);
    hi = 8'($random(seed));
    lo = 8'($random(seed));
    wr(UFC_ADDR_FMT, 8'h80);
    wr(UFC_ADDR_DATA, lo);
    wr(UFC_ADDR_DIVH, hi);
    rd(UFC_ADDR_DIVH, r);
    cmp_val(divisor, {hi, lo});
    cmp_val(16'(r), 16'(hi));
    rd(UFC_ADDR_DATA, r);
    cmp_val(16'(r), 16'(lo));
    wr(UFC_ADDR_FMT, 8'h00);
    wr(UFC_ADDR_FIFO, 8'h39);
    @(posedge core_clk);
    cmp_val(16'(dma_mode), 16'h1);
    wr(UFC_ADDR_FIFO, 8'h31);
    @(posedge core_clk);
    cmp_val(16'(dma_mode), 16'h0);
    for (int i = 0; i < 12; i++) wr(UFC_ADDR_DATA, 8'($random(seed)));
    repeat (2) @(posedge core_clk);
    cmp_val(16'(tx_request), 16'h1);
    wr(UFC_ADDR_FMT, UFC_ENH_KEY);
    wr(UFC_ADDR_FIFO, 8'h10);
    wr(3'h4, hi);
    rd(UFC_ADDR_FIFO, r);
    cmp_val(16'(r), 16'h0010);
    rd(3'h4, r);
    cmp_val(16'(r), 16'(hi));
    wr(UFC_ADDR_FMT, 8'h00);
    @(posedge core_clk);
    cmp_val(16'(enhanced_functions_enable), 16'h1);
    wr(UFC_ADDR_FIFO, 8'h31);
    repeat (2) @(posedge core_clk);
    cmp_val(16'(tx_request), 16'h0);
    wr(UFC_ADDR_FIFO, 8'h35);
    repeat (3) @(posedge core_clk);
    cmp_val(16'(tx_request), 16'h1);
    wait_tx(1'b1, 80);
    wr(UFC_ADDR_FMT, 8'h40);
    wait_tx(1'b0, 40);
    wr(UFC_ADDR_FMT, 8'h00);
    repeat (3) @(posedge core_clk);
    cmp_val(16'(tx_pin), 16'h1);
    // Every word length meets no, odd, even and one forced parity once
    for (int i = 0; i < 16; i++)
    begin
      fm = 8'($random(seed)) & 8'h04;
      fm[1:0] = i[1:0];
      fm[3] = i[3] | i[2];
      fm[4] = i[3] & (~i[2] | i[0]);
      fm[5] = i[3] & i[2];
      wr(UFC_ADDR_FMT, fm);
      d = 8'($random(seed));
      n = frame(fm, d, f);
      wr(UFC_ADDR_DATA, d);
      // Second copy follows at once, so its start bit ends the stop time
      wr(UFC_ADDR_DATA, d);
      wait_tx(1'b0, 1);
      t0 = $time;
      ufc_serial_peer_i.recv(n, g);
      cmp_val(16'(g), 16'(f));
      wait_tx(1'b0, 1);
      sl = int'(($time - t0) / 50) - 32 * (n - 1);
      cmp_val(16'(sl & ~1), fm[2] ? (fm[1:0] == 2'h0 ? 16'h0030 : 16'h0040) : 16'h0020);
      wait_tx(1'b1, 240);
      d = 8'($random(seed));
      n = frame(fm, d, f);
      ufc_serial_peer_i.send(f, n + 1);
      repeat (2) @(posedge core_clk);
      rd(UFC_ADDR_DATA, r);
      cmp_val(16'(r), 16'(d & (8'hff >> (3 - fm[1:0]))));
    end
    wr(UFC_ADDR_FMT, 8'h03);
    wr(UFC_ADDR_FIFO, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      n = frame(8'h03, 8'(i), f);
      ufc_serial_peer_i.send(f, n + 1);
      repeat (3) @(posedge core_clk);
      cmp_val(16'(rx_request), 16'(i == 7));
    end
    wr(UFC_ADDR_FIFO, 8'h41);
    repeat (2) @(posedge core_clk);
    cmp_val(16'(rx_request), 16'h0);
    wr(UFC_ADDR_FIFO, 8'h01);
    repeat (2) @(posedge core_clk);
    cmp_val(16'(rx_request), 16'h1);
    wr(UFC_ADDR_FIFO, 8'h03);
    repeat (3) @(posedge core_clk);
    cmp_val(16'(rx_request), 16'h0);
    summarize();
  end
  initial
  begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    summarize();
  end
endmodule : ufc_line_ctrl_tb
bind ufc_line_ctrl ufc_line_ctrl_assertions #(.DEPTH(DEPTH)) ufc_line_ctrl_assertions_i (
  .core_clk(core_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_cs(bus_cs),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .baud_tick16(baud_tick16),
  .rx_pin(rx_pin), .tx_pin(tx_pin), .rx_request(rx_request), .tx_request(tx_request),
  .dma_mode(dma_mode), .divisor(divisor), .enhanced_functions_enable(enhanced_functions_enable));
